// [verilog/wwdt_pkg.sv]
// Purpose: shared constants and types for the windowed watchdog
// Assumes: mclk at 200 MHz, watchdog base clock nominally 32 kHz
// Notes:   register indices are word offsets on the plain register port
package wwdt_pkg;
	localparam int unsigned MCLK_HZ      = 200_000_000;
	localparam int unsigned RC_OSC_HZ    = 32_000;
	localparam int unsigned RC_OSC_DIV   = MCLK_HZ / RC_OSC_HZ;
	localparam int unsigned BASE_MS_PRE0 = 1;
	localparam int unsigned BASE_MS_PRE1 = 4;
	localparam int unsigned PRE_LO       = RC_OSC_HZ * BASE_MS_PRE0 / 1000;
	localparam int unsigned PRE_HI       = RC_OSC_HZ * BASE_MS_PRE1 / 1000;

	localparam int AW = 4;
	localparam int DW = 16;
	localparam int CW = 23;

	localparam logic [AW-1:0] ADDR_RST_CTRL = 4'h0;
	localparam logic [AW-1:0] ADDR_CFG  = 4'h1;
	localparam logic [AW-1:0] ADDR_STS  = 4'h2;
	localparam logic [AW-1:0] ADDR_MSK  = 4'h3;
	localparam logic [AW-1:0] ADDR_CNT  = 4'h4;

	localparam int RC_SWEN = 5;
	localparam int RC_TMO  = 4;
	localparam int RC_SLP  = 3;
	localparam int RC_IDL  = 2;

	localparam int CF_FEN  = 7;
	localparam int CF_WOFF = 6;
	localparam int CF_UNIM = 5;
	localparam int CF_PRE  = 4;
	localparam int CF_POST = 0;

	localparam logic [7:0] CFG_ERASED = 8'hdf;
	localparam logic [7:0] CFG_IMPL   = 8'hdf;

	localparam int ST_TMO = 0;
	localparam int ST_WIN = 1;

	typedef enum logic [1:0] {
		pm_run,
		pm_sleep,
		pm_idle
	} wwdt_pm_e;
endpackage : wwdt_pkg

// [verilog/wwdt_tick_div.sv]
// Purpose: divides mclk down to the watchdog base tick
// Assumes: clr and en come from mclk logic
// Notes:   tick is a one-cycle registered pulse every DIV cycles while en
`timescale 1ns/1ps
module wwdt_tick_div
	import wwdt_pkg::*;
#(
	parameter int unsigned DIV = RC_OSC_DIV
) (
	input  wire logic mclk, // system clock
	input  wire logic rst,  // synchronous reset
	input  wire logic en,   // oscillator running
	input  wire logic clr,  // restart the phase
	output logic      tick  // one base-clock period elapsed
);
	localparam int W = $clog2(DIV);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} wwdt_div_s;

	wwdt_div_s st_reg;
	wwdt_div_s st_next;

	initial
	begin
		if (DIV < 2)
			$error("wwdt_tick_div: DIV must be at least 2");
	end

	always_comb
	begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (clr || !en)
			st_next.cnt = '0;
		else if (st_reg.cnt == W'(DIV - 1))
		begin
			st_next.cnt  = '0;
			st_next.tick = 1'b1;
		end
		else
			st_next.cnt = st_reg.cnt + W'(1);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
endmodule : wwdt_tick_div

// [verilog/wwdt_top.sv]
// Purpose: windowed watchdog with prescaler, postscaler and sleep wake-up
// Assumes: cpu strobes are one-cycle pulses on mclk; por implies rst
// Notes:   config word is write-once per bit until por
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int unsigned TICK_DIV = RC_OSC_DIV
) (
	input  wire logic          mclk,         // 200 mhz clock
	input  wire logic          rst,          // any device reset
	input  wire logic          por,          // power-on reset
	input  wire logic [AW-1:0] addr,         // register index
	input  wire logic [DW-1:0] wdata,        // write data
	input  wire logic          wr,           // write strobe
	input  wire logic          rd,           // read strobe
	output logic      [DW-1:0] rdata,        // read data, cycle after rd
	input  wire logic          clear_watchdog_instr, // clear instruction executed
	input  wire logic          power_save_instr,     // power-save instruction executed
	input  wire logic          power_save_idle,      // with power-save: 1 idle, 0 sleep
	input  wire logic          clk_sw_done,  // clock switch completed
	input  wire logic          wake_other,   // wake from another source
	output logic               rc_osc_en,    // low_power_rc_osc enable
	output logic               wdt_rst_req,  // device reset request pulse
	output logic               wake,         // wake-up pulse
	output logic               irq           // level interrupt
);
	typedef struct packed {
		logic [7:0]    cfg;
		logic [7:0]    lock;
		logic          swen;
		logic          tmo_flag;
		logic          slp;
		logic          idl;
		wwdt_pm_e      pm;
		logic [CW-1:0] cnt;
		logic [1:0]    sts;
		logic [1:0]    msk;
		logic [DW-1:0] rdata;
		logic          rst_req;
		logic          wake;
		logic          osc_en;
		logic          irq;
	} wwdt_state_s;

	wwdt_state_s st_reg;
	wwdt_state_s st_next;

	logic          tick;
	logic          wdt_en;
	logic          asleep;
	logic          cnt_clr;
	logic          win_open;
	logic          early_clr;
	logic          tmo;
	logic [CW-1:0] period;
	logic [CW-1:0] win_start;
	logic [DW-1:0] rd_mux;
	logic          wr_ctrl;
	logic          wr_cfg;

	initial
	begin
		if (TICK_DIV < 2)
			$error("wwdt_top: TICK_DIV must be at least 2");
		if (PRE_LO != 32 || PRE_HI != 128)
			$error("wwdt_top: base periods do not match the prescaler");
	end

	wwdt_tick_div #(
		.DIV  (TICK_DIV)
	) u_div (
		.mclk (mclk),
		.rst  (rst),
		.en   (st_reg.osc_en),
		.clr  (cnt_clr),
		.tick (tick)
	);

	assign asleep = (st_reg.pm != pm_run);
	// forced enable overrides the software bit
	assign wdt_en = st_reg.cfg[CF_FEN] | st_reg.swen;

	// period in base ticks: prescale times postscale
	always_comb
	begin
		period = st_reg.cfg[CF_PRE] ? CW'(PRE_HI) : CW'(PRE_LO);
		period = period << st_reg.cfg[CF_POST +: 4];
		win_start = period - (period >> 2);
	end

	assign win_open  = (st_reg.cnt >= win_start);
	// the window check applies only while awake and in window mode
	assign early_clr = clear_watchdog_instr && !asleep && wdt_en
		&& !st_reg.cfg[CF_WOFF] && !win_open;
	assign tmo = wdt_en && tick && !cnt_clr
		&& (st_reg.cnt == period - CW'(1));
	assign cnt_clr = (clear_watchdog_instr && !asleep) || power_save_instr || clk_sw_done
		|| (asleep && (wake_other || st_reg.wake));

	assign wr_ctrl = wr && (addr == ADDR_RST_CTRL);
	assign wr_cfg  = wr && (addr == ADDR_CFG);

	always_comb
	begin
		rd_mux = '0;
		unique case (addr)
			ADDR_RST_CTRL:
			begin
				rd_mux[RC_SWEN] = st_reg.swen;
				rd_mux[RC_TMO]  = st_reg.tmo_flag;
				rd_mux[RC_SLP]  = st_reg.slp;
				rd_mux[RC_IDL]  = st_reg.idl;
			end
			ADDR_CFG:
				rd_mux[7:0] = st_reg.cfg & CFG_IMPL;
			ADDR_STS:
				rd_mux[1:0] = st_reg.sts;
			ADDR_MSK:
				rd_mux[1:0] = st_reg.msk;
			ADDR_CNT:
				rd_mux = st_reg.cnt[CW-1 -: DW];
			default:
				rd_mux = '0;
		endcase
	end

	always_comb
	begin
		st_next         = st_reg;
		st_next.rst_req = 1'b0;
		st_next.wake    = 1'b0;
		st_next.rdata   = rd ? rd_mux : '0;

		// oscillator follows the enable; counts only on its ticks
		st_next.osc_en = wdt_en;

		if (cnt_clr)
			st_next.cnt = '0;
		else if (tmo)
			st_next.cnt = '0;
		else if (wdt_en && tick)
			st_next.cnt = st_reg.cnt + CW'(1);

		if (st_reg.pm != pm_run && (wake_other || st_reg.wake))
			st_next.pm = pm_run;
		else if (power_save_instr)
			st_next.pm = power_save_idle ? pm_idle : pm_sleep;

		// software may only clear the status flags; hardware set wins
		if (wr_ctrl)
		begin
			st_next.swen     = wdata[RC_SWEN];
			st_next.tmo_flag = st_reg.tmo_flag & wdata[RC_TMO];
			st_next.slp      = st_reg.slp & wdata[RC_SLP];
			st_next.idl      = st_reg.idl & wdata[RC_IDL];
		end
		if (power_save_instr)
		begin
			if (power_save_idle)
				st_next.idl = 1'b1;
			else
				st_next.slp = 1'b1;
		end

		if (tmo && asleep)
		begin
			st_next.wake     = 1'b1;
			st_next.tmo_flag = 1'b1;
		end
		else if (tmo || early_clr)
		begin
			st_next.rst_req  = 1'b1;
			st_next.tmo_flag = 1'b1;
		end

		if (wr_cfg)
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (!st_reg.lock[i] && CFG_IMPL[i])
				begin
					st_next.cfg[i]  = wdata[i];
					st_next.lock[i] = 1'b1;
				end
			end
		end

		if (wr && addr == ADDR_STS)
			st_next.sts = st_reg.sts & ~wdata[1:0];
		if (wr && addr == ADDR_MSK)
			st_next.msk = wdata[1:0];
		if (tmo)
			st_next.sts[ST_TMO] = 1'b1;
		if (early_clr)
			st_next.sts[ST_WIN] = 1'b1;
		st_next.irq = |(st_next.sts & st_next.msk);
	end

	// config, locks and reset flags survive device resets, not power-on
	always_ff @(posedge mclk)
	begin
		if (por)
		begin
			st_reg     <= '0;
			st_reg.cfg <= CFG_ERASED;
			st_reg.pm  <= pm_run;
		end
		else if (rst)
		begin
			st_reg.cfg   <= st_reg.cfg;
			st_reg.lock  <= st_reg.lock;
			st_reg.tmo_flag <= st_reg.tmo_flag;
			st_reg.slp   <= st_reg.slp;
			st_reg.idl   <= st_reg.idl;
			st_reg.sts   <= st_reg.sts;
			st_reg.msk   <= st_reg.msk;
			st_reg.irq   <= st_reg.irq;
			st_reg.swen  <= 1'b0;
			st_reg.pm    <= pm_run;
			st_reg.cnt   <= '0;
			st_reg.rdata <= '0;
			st_reg.rst_req <= 1'b0;
			st_reg.wake  <= 1'b0;
			st_reg.osc_en <= st_reg.cfg[CF_FEN];
		end
		else
			st_reg <= st_next;
	end

	assign rdata       = st_reg.rdata;
	assign rc_osc_en   = st_reg.osc_en;
	assign wdt_rst_req = st_reg.rst_req;
	assign wake        = st_reg.wake;
	assign irq         = st_reg.irq;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst || por);

	sequence s_sleep_tmo;
		tmo && asleep;
	endsequence

	sequence s_woken;
		wake && !wdt_rst_req ##1 !asleep && st_reg.cnt == '0;
	endsequence

	property p_osc_follows;
		wdt_en |=> rc_osc_en;
	endproperty
	a_osc_follows: assert property (p_osc_follows)
		else $error("oscillator off while watchdog enabled");

	property p_tmo_count;
		tmo |-> st_reg.cnt == period - CW'(1)
			&& period == ((st_reg.cfg[CF_PRE] ? 23'h80 : 23'h20)
			<< st_reg.cfg[3:0]);
	endproperty
	a_tmo_count: assert property (p_tmo_count)
		else $error("time-out at wrong count");

	property p_clr_counts;
		(clear_watchdog_instr && !asleep) || power_save_instr || clk_sw_done
			|=> st_reg.cnt == '0;
	endproperty
	a_clr_counts: assert property (p_clr_counts)
		else $error("counter not cleared");

	property p_sleep_wake;
		s_sleep_tmo |=> s_woken;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake)
		else $error("sleep time-out did not wake cleanly");

	property p_flag_sticky;
		st_reg.tmo_flag && !wr_ctrl |=> st_reg.tmo_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("time-out flag lost");

	property p_forced;
		st_reg.cfg[CF_FEN] && wr_ctrl && !wdata[RC_SWEN] |=> ##1 rc_osc_en;
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced watchdog stopped by software");

	property p_swen_reset;
		@(posedge mclk) disable iff (por) rst |=> !st_reg.swen;
	endproperty
	a_swen_reset: assert property (p_swen_reset)
		else $error("software enable survived reset");

	property p_early;
		early_clr |=> wdt_rst_req && st_reg.tmo_flag && st_reg.sts[ST_WIN];
	endproperty
	a_early: assert property (p_early)
		else $error("early clear did not reset");

	property p_cfg_read;
		rd && addr == ADDR_CFG |=> rdata[CF_UNIM] == 1'b0 && rdata[15:8] == 8'h00;
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("unimplemented config bit reads one");

	property p_write_once;
		wr_cfg && st_reg.lock == 8'hdf |=> $stable(st_reg.cfg);
	endproperty
	a_write_once: assert property (p_write_once)
		else $error("locked config changed");

	property p_awake_tmo;
		tmo && !asleep |=> wdt_rst_req && st_reg.tmo_flag && !wake;
	endproperty
	a_awake_tmo: assert property (p_awake_tmo)
		else $error("awake time-out did not reset");

	// another wake source must also restart the count from zero
	property p_wake_clr;
		asleep && wake_other |=> !asleep && st_reg.cnt == '0;
	endproperty
	a_wake_clr: assert property (p_wake_clr)
		else $error("wake did not clear the counter");

	property p_nonwin;
		clear_watchdog_instr && st_reg.cfg[CF_WOFF] |=> !wdt_rst_req;
	endproperty
	a_nonwin: assert property (p_nonwin)
		else $error("clear in non-window mode reset the device");
endmodule : wwdt_top

// [tb/wwdt_top_test.sv]
// Purpose: self-checking bench for the windowed watchdog
// Assumes: TICK_DIV cut to 4 so one base tick is 4 mclk cycles
// Notes:   period checks allow a few cycles of pipeline slack
`timescale 1ns/1ps
module wwdt_top_test import wwdt_pkg::*;;
	localparam int TD = 4;
	logic          mclk        = 1'h0;
	logic          rst         = 1'h1;
	logic          por         = 1'h1;
	logic [AW-1:0] addr        = '0;
	logic [DW-1:0] wdata       = '0;
	logic          wr          = 1'h0;
	logic          rd          = 1'h0;
	logic [DW-1:0] rdata;
	logic          clr_instr   = 1'h0;
	logic          psv_instr   = 1'h0;
	logic          psv_idle    = 1'h0;
	logic          clk_sw_done = 1'h0;
	logic          wake_other  = 1'h0;
	logic          rc_osc_en;
	logic          wdt_rst_req;
	logic          wake;
	logic          irq;
	int            failures    = 0;
	int            checks_done = 0;

	wwdt_top #(.TICK_DIV(TD)) u_dut (
		.mclk(mclk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .clear_watchdog_instr(clr_instr), .power_save_instr(psv_instr),
		.power_save_idle(psv_idle), .clk_sw_done(clk_sw_done), .wake_other(wake_other),
		.rc_osc_en(rc_osc_en),
		.wdt_rst_req(wdt_rst_req), .wake(wake), .irq(irq)
	);

	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic check(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
		@(posedge mclk);
		wr    <= 1'h1;
		addr  <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'h0;
	endtask : wr_reg

	task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] exp);
		@(posedge mclk);
		rd   <= 1'h1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'h0;
		#1 check(nm, rdata, exp);
	endtask : rchk

	task automatic do_rst(input logic p);
		@(posedge mclk);
		rst <= 1'h1;
		por <= p;
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		por <= 1'h0;
	endtask : do_rst

	// one pulse of a clearing event; k 2 and 3 enter sleep and idle
	task automatic pulse(input int k);
		@(posedge mclk);
		clr_instr   <= 1'(k == 0);
		clk_sw_done <= 1'(k == 1);
		psv_instr   <= 1'(k >= 2);
		psv_idle    <= 1'(k == 3);
		@(posedge mclk);
		clr_instr   <= 1'h0;
		clk_sw_done <= 1'h0;
		psv_instr   <= 1'h0;
	endtask : pulse

	task automatic wait_evt(input int lim, output int n);
		n = 0;
		// let the edge that ended the request settle, or a one-cycle pulse is missed
		#1;
		while (wdt_rst_req !== 1'h1 && wake !== 1'h1)
		begin
			@(posedge mclk);
			#1;
			n++;
			if (n >= lim)
			begin
				failures++;
				conclude();
			end
		end
	endtask : wait_evt

	// the 60-cycle lead-in leaves a partial count that the pulse must clear
	task automatic timed(input logic [7:0] cfg, input int k, input int ticks);
		int n;
		do_rst(1'h1);
		wr_reg(ADDR_CFG, {8'h00, cfg});
		wr_reg(ADDR_MSK, 16'h0001);
		repeat (60) @(posedge mclk);
		pulse(k);
		wait_evt(ticks * TD + 40, n);
		check("period", 16'(n >= ticks * TD - 2 && n <= ticks * TD + 6), 16'h0001);
		check("wake", 16'(wake), 16'(k >= 2));
		check("reset", 16'(wdt_rst_req), 16'(k < 2));
		rchk("rst_ctrl", ADDR_RST_CTRL, {11'h000, 1'h1, 1'(k == 2), 1'(k == 3), 2'h0});
		if (k == 0)
		begin
			check("irq", 16'(irq), 16'h0001);
			wr_reg(ADDR_STS, 16'h0001);
			@(posedge mclk);
			#1 check("irq_clr", 16'(irq), 16'h0000);
		end
		wr_reg(ADDR_RST_CTRL, 16'h0000);
		rchk("rst_ctrl_clr", ADDR_RST_CTRL, 16'h0000);
		$display("test timed %0d done", k);
	endtask : timed

	initial
	begin
		int n;
		do_rst(1'h1);
		repeat (2) @(posedge mclk);
		#1 check("osc_on", 16'(rc_osc_en), 16'h0001);
		rchk("cfg_erased", ADDR_CFG, 16'h00df);
		rchk("rst_ctrl_rst", ADDR_RST_CTRL, 16'h0000);
		wr_reg(4'hf, 16'hffff);
		rchk("unmapped", 4'hf, 16'h0000);
		$display("test reset done");
		do_rst(1'h1);
		wr_reg(ADDR_CFG, 16'h0000);
		rchk("cfg", ADDR_CFG, 16'h0000);
		wr_reg(ADDR_CFG, 16'h00ff);
		rchk("cfg_locked", ADDR_CFG, 16'h0000);
		check("osc_off", 16'(rc_osc_en), 16'h0000);
		wr_reg(ADDR_RST_CTRL, 16'h0020);
		repeat (2) @(posedge mclk);
		#1 check("osc_sw", 16'(rc_osc_en), 16'h0001);
		pulse(0);
		wait_evt(8, n);
		check("early", 16'(wdt_rst_req), 16'h0001);
		rchk("early_sts", ADDR_STS, 16'h0002);
		do_rst(1'h0);
		rchk("rst_ctrl_kept", ADDR_RST_CTRL, 16'h0010);
		check("osc_rst", 16'(rc_osc_en), 16'h0000);
		rchk("cfg_kept", ADDR_CFG, 16'h0000);
		$display("test window done");
		timed(8'hc0, 0, 32);
		timed(8'hd1, 1, 256);
		timed(8'hc2, 2, 128);
		timed(8'hc0, 3, 32);
		pulse(2);
		wake_other <= 1'h1;
		@(posedge mclk);
		wake_other <= 1'h0;
		#1 check("no_wake", 16'(wake), 16'h0000);
		rchk("wake_other", ADDR_RST_CTRL, 16'h0008);
		$display("test wake done");
		conclude();
	end
endmodule : wwdt_top_test
